/* File: core/pdh_pkg.sv */
/*
  Shared constants for the pin-controlled power-down hold block.
  Assumes a single 250 MHz core clock and no software-visible registers.
*/
package pdh_pkg;

  // ----------------------------------------------------------------
  // Clock
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;

  // ----------------------------------------------------------------
  // Power-down timing, printed figures
  // ----------------------------------------------------------------
  localparam int SETUP_FAST_NS  = 15;
  localparam int SETUP_SLOW_NS  = 20;
  localparam int DONT_FAST_NS   = 25;
  localparam int DONT_SLOW_NS   = 30;
  localparam int WAKE_MAX_US    = 1;

  // Longest time rounds down to whole cycles
  localparam int WAKE_MAX_CYCLES = (WAKE_MAX_US * 1000000) / CLK_PERIOD_PS;
  // Hold-off of the far side before inputs may change, rounded up
  localparam int DONT_SLOW_CYCLES = (DONT_SLOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Wake sequence and reset values
  // ----------------------------------------------------------------
  localparam int WAKE_CYCLES     = 4;
  localparam int WAKE_CNT_W      = 8;
  localparam logic RST_OPTION    = 1'b0;
  localparam logic RST_FREEZE    = 1'b0;
  localparam logic RST_OE_N      = 1'b1;
  localparam logic RST_LEVEL     = 1'b0;

  // ----------------------------------------------------------------
  // Sequencer states, Gray along run -> hold -> wake; wake -> run flips both bits
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PDH_RUN  = 2'b00,
    PDH_HOLD = 2'b01,
    PDH_WAKE = 2'b11
  } pdh_state_type;

endpackage

/* File: core/pdh_pin_keeper.sv */
/*
  Hold latches for a group of input pins.
  Assumes pin levels are synchronous to the core clock.
*/
`timescale 1ns/1ns
`default_nettype none

module pdh_pin_keeper #(
  parameter int WIDTH = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_hold,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  // ----------------------------------------------------------------
  // Keeper bits
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gen_keep
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          o_level[g] <= pdh_pkg::RST_LEVEL;
        end else if (!i_hold) begin
          o_level[g] <= i_pin[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

/* File: core/pdh_power_down_hold.sv */
/*
  Pin-controlled power-down hold: freezes pad outputs, enables and the
  user logic, blocks inputs and keeps pin levels while the power-down pin
  is high.
  Assumes the user logic honours o_core_freeze by holding its registers,
  and the outside world meets the setup and hold-off around the pin edge.
*/
`timescale 1ns/1ns
`default_nettype none

module pdh_power_down_hold #(
  parameter int IN_W   = 4,
  parameter int IO_W   = 8,
  parameter int OUT_W  = 8
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_pd_option,
  input  wire logic             i_power_down_pin,
  input  wire logic [IN_W-1:0]  i_pad_in,
  input  wire logic [IO_W-1:0]  i_pad_io_in,
  input  wire logic [OUT_W-1:0] i_core_out,
  input  wire logic [OUT_W-1:0] i_core_oe_n,
  output logic      [IN_W-1:0]  o_core_in,
  output logic      [IO_W-1:0]  o_core_io_in,
  output logic                  o_pd_array_in,
  output logic      [OUT_W-1:0] o_pad_out,
  output logic      [OUT_W-1:0] o_pad_oe_n,
  output logic                  o_core_freeze,
  output logic                  o_powered_down
);

  // ----------------------------------------------------------------
  // Option strap, caught after reset release
  // ----------------------------------------------------------------
  logic pd_option;
  logic option_taken;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_option    <= pdh_pkg::RST_OPTION;
      option_taken <= 1'b0;
    end else if (!option_taken) begin
      pd_option    <= i_pd_option;
      option_taken <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State decoding
  // ----------------------------------------------------------------
  // Any state but run keeps the pads and user inputs still
  function automatic logic pdh_holding(input pdh_pkg::pdh_state_type st);
    begin
      pdh_holding = (st != pdh_pkg::PDH_RUN);
    end
  endfunction

  // Only the hold state stops user registers; wake lets them settle
  function automatic logic pdh_freezing(input pdh_pkg::pdh_state_type st);
    begin
      pdh_freezing = (st == pdh_pkg::PDH_HOLD);
    end
  endfunction

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  pdh_pkg::pdh_state_type state;
  pdh_pkg::pdh_state_type next_state;
  logic [pdh_pkg::WAKE_CNT_W-1:0] wake_cnt;
  logic pd_req;
  logic hold;

  assign pd_req = pd_option && i_power_down_pin;
  assign hold   = pdh_holding(state);

  always_comb begin
    next_state = state;
    case (state)
      pdh_pkg::PDH_RUN: begin
        if (pd_req) begin
          next_state = pdh_pkg::PDH_HOLD;
        end
      end
      pdh_pkg::PDH_HOLD: begin
        if (!pd_req) begin
          next_state = pdh_pkg::PDH_WAKE;
        end
      end
      pdh_pkg::PDH_WAKE: begin
        if (pd_req) begin
          next_state = pdh_pkg::PDH_HOLD;
        end else if (wake_cnt == pdh_pkg::WAKE_CNT_W'(pdh_pkg::WAKE_CYCLES - 1)) begin
          next_state = pdh_pkg::PDH_RUN;
        end
      end
      default: begin
        next_state = pdh_pkg::PDH_RUN;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= pdh_pkg::PDH_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Wake counter
  // ----------------------------------------------------------------
  // Short fixed wake: far below the allowed bound, so pads come back
  // early; user logic gets a few cycles to settle before pads follow.
  // bounded wake time
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wake_cnt <= '0;
    end else if (state == pdh_pkg::PDH_WAKE) begin
      wake_cnt <= wake_cnt + 1'b1;
    end else begin
      wake_cnt <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Freeze and status
  // ----------------------------------------------------------------
  // Freeze follows the pin: asserted on the first sampled high so nothing
  // seen after the far side's hold-off can reach user state.
  // user logic frozen
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_freeze  <= pdh_pkg::RST_FREEZE;
      o_powered_down <= 1'b0;
    end else begin
      o_core_freeze  <= pdh_freezing(next_state);
      o_powered_down <= pdh_holding(next_state);
    end
  end

  // ----------------------------------------------------------------
  // Pad outputs and enables
  // ----------------------------------------------------------------
  // output values held
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad_out  <= '0;
      o_pad_oe_n <= {OUT_W{pdh_pkg::RST_OE_N}};
    end else if (!pd_req && !hold) begin
      o_pad_out  <= i_core_out;
      o_pad_oe_n <= i_core_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // Input blocking and hold latches
  // ----------------------------------------------------------------
  logic in_hold;

  // block as soon as pin seen high
  assign in_hold = pd_req || hold;

  pdh_pin_keeper #(
    .WIDTH (IN_W)
  ) u_keep_in (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_hold     (in_hold),
    .i_pin      (i_pad_in),
    .o_level    (o_core_in)
  );

  pdh_pin_keeper #(
    .WIDTH (IO_W)
  ) u_keep_io (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_hold     (in_hold),
    .i_pin      (i_pad_io_in),
    .o_level    (o_core_io_in)
  );

  // ----------------------------------------------------------------
  // Array input of the power-down pin
  // ----------------------------------------------------------------
  // Held low until the strap is known, so no glitch reaches user logic
  // when the feature turns out to be selected.
  // array input withdrawn with option
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pd_array_in <= 1'b0;
    end else if (pd_option || !option_taken) begin
      o_pd_array_in <= 1'b0;
    end else begin
      o_pd_array_in <= i_power_down_pin;
    end
  end

endmodule

`default_nettype wire

/* File: verif/pdh_power_down_hold_assertions.sv */
/*
  Port-level checker for the power-down hold block.
  Assumes the strap only changes while reset is held.
*/
`timescale 1ns/1ns
`default_nettype none

module pdh_power_down_hold_assertions #(
  parameter int IN_W  = 4,
  parameter int IO_W  = 8,
  parameter int OUT_W = 8
) (
  input wire logic             i_core_clk,
  input wire logic             i_rst_n,
  input wire logic             i_pd_option,
  input wire logic             i_power_down_pin,
  input wire logic [IN_W-1:0]  i_pad_in,
  input wire logic [OUT_W-1:0] i_core_out,
  input wire logic [IN_W-1:0]  o_core_in,
  input wire logic [IO_W-1:0]  o_core_io_in,
  input wire logic             o_pd_array_in,
  input wire logic [OUT_W-1:0] o_pad_out,
  input wire logic [OUT_W-1:0] o_pad_oe_n,
  input wire logic             o_core_freeze,
  input wire logic             o_powered_down
);
  logic [1:0] age;

  // Strap is not taken before the first edge
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age <= 2'h0;
    end else if (age != 2'h2) begin
      age <= age + 2'h1;
    end
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence wake_quiet;
    $fell(o_core_freeze) ##0 (!i_power_down_pin) [*8];
  endsequence
  sequence running;
    !o_powered_down && !$past(o_powered_down) && !i_power_down_pin && age == 2'h2;
  endsequence

  a_entry_freeze: assert property (
    i_pd_option && i_power_down_pin && age != 2'h0 |=> o_core_freeze && o_powered_down)
    else $error("no freeze after pin high");
  a_freeze_release: assert property (
    o_core_freeze && !i_power_down_pin |=> !o_core_freeze && o_powered_down)
    else $error("freeze not released");
  a_wake_bound: assert property (wake_quiet |-> !o_powered_down)
    else $error("wake too long");
  a_outputs_held: assert property (
    o_powered_down |-> $stable(o_pad_out) && $stable(o_pad_oe_n))
    else $error("pad moved in power-down");
  a_inputs_blocked: assert property (
    o_powered_down |-> $stable(o_core_in) && $stable(o_core_io_in))
    else $error("input passed in power-down");
  a_option_off: assert property (!i_pd_option |-> !o_powered_down && !o_core_freeze)
    else $error("power-down without option");
  a_array_hidden: assert property (i_pd_option |-> !o_pd_array_in)
    else $error("array input visible");
  a_run_tracks: assert property (
    running |=> o_pad_out == $past(i_core_out) && o_core_in == $past(i_pad_in))
    else $error("no tracking in run");
endmodule

bind pdh_power_down_hold pdh_power_down_hold_assertions #(.IN_W(IN_W), .IO_W(IO_W), .OUT_W(OUT_W))
  pdh_chk_i (.i_core_clk, .i_rst_n, .i_pd_option, .i_power_down_pin, .i_pad_in, .i_core_out,
    .o_core_in, .o_core_io_in, .o_pd_array_in, .o_pad_out, .o_pad_oe_n, .o_core_freeze,
    .o_powered_down);

`default_nettype wire

/* File: verif/pdh_far_model.sv */
/*
  Far-side logic: raises the power-down pin on request and drives pads.
  Assumes slow-grade margins, rounded up to whole 4 ns cycles.
*/
`timescale 1ns/1ns
`default_nettype none

module pdh_far_model #(
  parameter int SETUP_CYC = 5,
  parameter int HOLD_CYC  = 8
) (
  input  wire logic  i_core_clk,
  input  wire logic  i_sleep,
  output logic       o_power_down_pin = 1'b0,
  output logic [3:0] o_pad_in = 4'h0,
  output logic [7:0] o_pad_io_in = 8'h00
);
  int quiet = 0;

  always @(posedge i_core_clk) begin
    quiet <= i_sleep ? quiet + 1 : 0;
    if (i_sleep && quiet == SETUP_CYC) begin
      o_power_down_pin <= 1'b1;
    end
    if (!i_sleep) begin
      o_power_down_pin <= 1'b0;
    end
    if (!i_sleep || quiet > SETUP_CYC + HOLD_CYC) begin
      o_pad_in    <= 4'($urandom);
      o_pad_io_in <= 8'($urandom);
    end
  end
endmodule

`default_nettype wire

/* File: verif/tb_top.sv */
/*
  Bench for the power-down hold block.
  Assumes the far-side model owns the pin and the input pads.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic        clk = 1'b0, rst_n = 1'b0, opt = 1'b1, sleep = 1'b0, hold_io = 1'b0;
  logic        pin, freeze, pdn, arr, was_frozen = 1'b0;
  logic [3:0]  pad_in, core_in;
  logic [7:0]  io_in, core_io, pad_out, pad_oe_n, core_out = 8'h00, oe_n = 8'hFF;
  logic [27:0] notes[$];
  int          failures = 0, checks_done = 0, n;

  pdh_power_down_hold pdh_power_down_hold_i (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_pd_option(opt), .i_power_down_pin(pin), .i_pad_in(pad_in), .i_pad_io_in(io_in),
    .i_core_out(core_out), .i_core_oe_n(oe_n), .o_core_in(core_in), .o_core_io_in(core_io),
    .o_pd_array_in(arr), .o_pad_out(pad_out), .o_pad_oe_n(pad_oe_n), .o_core_freeze(freeze),
    .o_powered_down(pdn));
  pdh_far_model pdh_far_model_i (.i_core_clk(clk), .i_sleep(sleep), .o_power_down_pin(pin),
    .o_pad_in(pad_in), .o_pad_io_in(io_in));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic check(input string name, input logic [27:0] exp, input logic [27:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // User outputs wander unless held around the pin edge
  always @(posedge clk) begin
    was_frozen <= freeze;
    if (!hold_io) begin
      core_out <= 8'($urandom);
      oe_n     <= 8'($urandom);
    end
    if (was_frozen && !freeze && notes.size() > 0) begin
      check("frozen state", notes.pop_front(), {pad_out, pad_oe_n, core_in, core_io});
    end
  end

  task automatic nap(input int len);
    sleep   <= 1'b1;
    hold_io <= 1'b1;
    for (n = 0; pin !== 1'b1 && n < 20; n++) begin
      @(posedge clk);
    end
    notes.push_back({core_out, oe_n, pad_in, io_in});
    repeat (9) @(posedge clk);
    hold_io <= 1'b0;
    repeat (len) @(posedge clk);
    sleep <= 1'b0;
    for (n = 0; pdn !== 1'b0 && n < 300; n++) begin
      @(posedge clk);
    end
    check("wake cycles", 28'(n < 252), 28'h1);
  endtask

  initial begin
    void'($urandom(37));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      nap(i * 7 + 1);
    end
    repeat (3) @(posedge clk);
    check("notes left", 28'(notes.size()), 28'h0);
    rst_n <= 1'b0;
    opt   <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    sleep <= 1'b1;
    repeat (12) @(posedge clk);
    check("array input", 28'({pdn, arr}), 28'h1);
    complete_run;
  end

  // Whole run needs about two hundred cycles
  initial begin
    #80000;
    failures++;
    complete_run;
  end
endmodule

`default_nettype wire
